//--- dcb_pkg.sv
package dcb_pkg;
  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ADDR_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] MODE_OFS = 8'h0C;
  localparam logic [7:0] WDATA_OFS = 8'h10;
  localparam logic [7:0] RDATA_OFS = 8'h14;
  localparam logic [7:0] TIME_OFS = 8'h18;
  // ----------------------------------------------------------------
  // CTRL fields
  // ----------------------------------------------------------------
  localparam int CTRL_CMD_LSB = 0;
  localparam int CTRL_BANK_LSB = 4;
  localparam int CTRL_AUTOPRE_BIT = 8;
  localparam int CTRL_ALLBANK_BIT = 9;
  localparam int CTRL_GO_BIT = 31;
  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int BURST_LENGTH_LSB = 0;
  localparam int BURST_ORDER_BIT = 3;
  localparam int READ_LATENCY_LSB = 4;
  localparam int DLL_RESET_SELFCLEAR_BIT = 8;
  localparam int WRITE_RECOVERY_LSB = 9;
  localparam logic [12:0] MODE_REG_VALID_MASK = 13'h1FFF;
  localparam logic [2:0] BL4_CODE = 3'h2;
  localparam logic [2:0] BL8_CODE = 3'h3;
  localparam logic [16:0] MODE_RESET_VAL = 17'h00632;
  localparam logic [31:0] TIME_RESET_VAL = 32'h00000000;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int WRITE_TO_READ_DELAY_NS = 10;
  localparam int WTR_CYC_RAW =
    (WRITE_TO_READ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WTR_CYC = (WTR_CYC_RAW > 2) ? WTR_CYC_RAW : 2;
  localparam int MODE_LOAD_DELAY_CYC = 2;
  localparam int ROW_PRECHARGE_CYC = 4;
  localparam int ACT_TO_COL_CYC = 4;
  localparam int REFRESH_CYC = 26;
  localparam int DLL_LOCK_CYC = 200;
  localparam int WRITE_RECOVERY_CYC = 3;
  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NOP, CMD_MODE, CMD_ACT, CMD_READ, CMD_WRITE,
    CMD_PRE, CMD_REF, CMD_SREF, CMD_SREX
  } dcb_cmd_type;
endpackage

//--- dcb_counter.sv
`timescale 1ns/1ps
module dcb_counter import dcb_pkg::*; #(
  parameter int WIDTH = 9
) (
  sys_clk,
  rst_b,
  load,
  loadVal,
  busy
);
  input wire logic sys_clk;
  input wire logic rst_b;
  input wire logic load;
  input wire logic [WIDTH-1:0] loadVal;
  output logic busy;

  logic [WIDTH-1:0] cnt_r;

  initial begin
    if (WIDTH < 2) $error("WIDTH too small");
  end

  // ----------------------------------------------------------------
  // Down counter, reload only takes a value larger than the remaining count
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (load) begin
      if (loadVal > cnt_r) begin
        cnt_r <= loadVal;
      end
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign busy = (cnt_r != '0);
endmodule

//--- dcb_host.sv
`timescale 1ns/1ps
// Summary of operation
// - Spaces commands after auto-precharge bursts by the listed bank gaps.
// - Write-to-read gap is the larger of two clocks or time over period.
// - Other banks may be commanded while an auto-precharged bank is still precharging.
// - Refresh and mode load only with all banks idle, no burst.
// - No executable command until the mode load delay has passed.
// - Activate opens a row; another row needs precharge first.
// - Reads and writes only go to activated banks.
// - Refresh uses internal row address; host reissues each time.
// - Mode load always writes complete contents; DLL reset self-clears.
// - Reserved mode bits are written as zero.
// - Two hundred clocks after DLL reset before any read.
module dcb_host import dcb_pkg::*; #(
  parameter int DATA_WIDTH = 8,
  parameter int ADDR_WIDTH = 14,
  parameter int BANKS = 8
) (
  sys_clk,
  rst_b,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  memCke,
  memCs_b,
  memRas_b,
  memCas_b,
  memWe_b,
  memBank,
  memAddr,
  memDqOut,
  memDqIn,
  memDqOe,
  memByteWriteMask
);
  localparam int BW = $clog2(BANKS);
  input wire logic sys_clk;
  input wire logic rst_b;
  input wire logic psel;
  input wire logic penable;
  input wire logic pwrite;
  input wire logic [7:0] paddr;
  input wire logic [31:0] pwdata;
  output logic [31:0] prdata;
  output logic pready;
  output logic pslverr;
  output logic memCke;
  output logic memCs_b;
  output logic memRas_b;
  output logic memCas_b;
  output logic memWe_b;
  output logic [2:0] memBank;
  output logic [ADDR_WIDTH-1:0] memAddr;
  output logic [DATA_WIDTH-1:0] memDqOut;
  input wire logic [DATA_WIDTH-1:0] memDqIn;
  output logic memDqOe;
  output logic memByteWriteMask;

  initial begin
    if (ADDR_WIDTH < 13 || ADDR_WIDTH > 14) $error("ADDR_WIDTH 13..14");
    if (BANKS != 8) $error("BANKS must be 8");
    if (DATA_WIDTH < 1 || DATA_WIDTH > 8) $error("DATA_WIDTH 1..8");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_ISSUE, ST_WDATA, ST_RWAIT, ST_RDATA, ST_GAP
  } dcb_state_type;

  dcb_state_type state_r;
  logic [31:0] ctrl_r;
  logic [ADDR_WIDTH-1:0] addr_r;
  logic [16:0] mode_r;
  logic [31:0] wdata_r;
  logic [31:0] rdata_r;
  logic [31:0] time_r;
  logic errFlag_r;
  logic selfRef_r;
  logic [BANKS-1:0] open_r;
  logic [3:0] beat_r;
  logic [3:0] lat_r;
  logic [8:0] gapLoad;
  logic gapBusy;
  logic [8:0] dllLoad;
  logic dllBusy;
  logic [BANKS-1:0] preLoad;
  logic [BANKS-1:0] preBusy;
  logic [DATA_WIDTH-1:0] dqS1_r;
  logic [DATA_WIDTH-1:0] dqS2_r;
  logic apbWr;
  logic apbRd;
  logic startReq;
  logic legal;
  dcb_cmd_type cmd;
  logic [BW-1:0] bank;
  logic [3:0] bl;
  logic [3:0] rl;
  logic [3:0] wr;
  logic [2:0] beatIdx;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  function automatic logic [3:0] burstBeats(input logic [2:0] code);
    burstBeats = (code == BL8_CODE) ? 4'h4 : 4'h2;
  endfunction

  assign cmd = dcb_cmd_type'(ctrl_r[CTRL_CMD_LSB +: 4]);
  assign bank = ctrl_r[CTRL_BANK_LSB +: BW];
  assign bl = burstBeats(mode_r[BURST_LENGTH_LSB +: 3]);
  assign rl = {1'b0, mode_r[READ_LATENCY_LSB +: 3]};
  assign wr = {1'b0, mode_r[WRITE_RECOVERY_LSB +: 3]} + 4'h1;
  assign beatIdx = 3'({bl[2:0], 1'b0} - beat_r);

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && (paddr > TIME_OFS);
  assign startReq = apbWr && (paddr == CTRL_OFS) && pwdata[CTRL_GO_BIT];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= '0;
      addr_r <= '0;
      mode_r <= MODE_RESET_VAL;
      wdata_r <= '0;
      time_r <= TIME_RESET_VAL;
    end else if (apbWr && state_r == ST_IDLE) begin
      case (paddr)
        CTRL_OFS: ctrl_r <= pwdata;
        ADDR_OFS: addr_r <= pwdata[ADDR_WIDTH-1:0];
        MODE_OFS: mode_r <= {4'h0, pwdata[12:0] & MODE_REG_VALID_MASK};
        WDATA_OFS: wdata_r <= pwdata;
        TIME_OFS: time_r <= pwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= '0;
    end else if (apbRd) begin
      case (paddr)
        CTRL_OFS: prdata <= ctrl_r;
        ADDR_OFS: prdata <= 32'(addr_r);
        STAT_OFS: prdata <= {20'h0, preBusy, selfRef_r, errFlag_r,
                             dllBusy, state_r != ST_IDLE || gapBusy};
        MODE_OFS: prdata <= {15'h0, mode_r};
        WDATA_OFS: prdata <= wdata_r;
        RDATA_OFS: prdata <= rdata_r;
        TIME_OFS: prdata <= time_r;
        default: prdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Legality check before issue
  // ----------------------------------------------------------------
  always_comb begin
    legal = 1'b1;
    case (cmd)
      CMD_MODE, CMD_REF, CMD_SREF: begin
        legal = (open_r == '0) && (preBusy == '0);
      end
      CMD_ACT: legal = !open_r[bank] && !preBusy[bank];
      CMD_READ: legal = open_r[bank] && !dllBusy;
      CMD_WRITE: legal = open_r[bank];
      CMD_SREX: legal = selfRef_r;
      default: legal = 1'b1;
    endcase
    if (selfRef_r && cmd != CMD_SREX) begin
      legal = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      beat_r <= '0;
      lat_r <= '0;
      errFlag_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (apbWr && paddr == STAT_OFS && pwdata[2]) begin
            errFlag_r <= 1'b0;
          end
          if (startReq && !gapBusy) begin
            state_r <= ST_ISSUE;
          end else if (startReq) begin
            errFlag_r <= 1'b1;
          end
        end
        ST_ISSUE: begin
          if (!legal) begin
            errFlag_r <= 1'b1;
            state_r <= ST_IDLE;
          end else if (cmd == CMD_WRITE) begin
            lat_r <= rl - 4'h1;
            beat_r <= {bl[2:0], 1'b0};
            state_r <= ST_WDATA;
          end else if (cmd == CMD_READ) begin
            lat_r <= rl + 4'h4;
            beat_r <= {bl[2:0], 1'b0};
            state_r <= ST_RWAIT;
          end else begin
            state_r <= ST_GAP;
          end
        end
        ST_WDATA: begin
          if (lat_r != '0) begin
            lat_r <= lat_r - 4'h1;
          end else if (beat_r == 4'h1) begin
            state_r <= ST_GAP;
          end else begin
            beat_r <= beat_r - 4'h1;
          end
        end
        ST_RWAIT: begin
          if (lat_r <= 4'h2) begin
            state_r <= ST_RDATA;
          end else begin
            lat_r <= lat_r - 4'h1;
          end
        end
        ST_RDATA: begin
          if (beat_r == 4'h1) begin
            state_r <= ST_GAP;
          end else begin
            beat_r <= beat_r - 4'h1;
          end
        end
        ST_GAP: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Spacing after each command
  // ----------------------------------------------------------------
  always_comb begin
    gapLoad = 9'h000;
    dllLoad = 9'h000;
    if (state_r == ST_ISSUE && legal) begin
      case (cmd)
        CMD_MODE: begin
          gapLoad = 9'(MODE_LOAD_DELAY_CYC);
          if (mode_r[DLL_RESET_SELFCLEAR_BIT]) begin
            dllLoad = 9'(DLL_LOCK_CYC);
          end
        end
        CMD_REF: gapLoad = 9'(REFRESH_CYC);
        CMD_ACT: gapLoad = 9'(ACT_TO_COL_CYC);
        CMD_READ: gapLoad = 9'(rl + bl + 4'h2);
        CMD_WRITE: gapLoad = 9'(rl + bl + 9'(WTR_CYC));
        default: gapLoad = 9'h001;
      endcase
    end
  end

  dcb_counter #(.WIDTH(9)) gapCnt (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .load(gapLoad != 9'h000),
    .loadVal(gapLoad),
    .busy(gapBusy)
  );

  dcb_counter #(.WIDTH(9)) dllCnt (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .load(dllLoad != 9'h000),
    .loadVal(dllLoad),
    .busy(dllBusy)
  );

  // ----------------------------------------------------------------
  // Per-bank open rows and precharge timers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < BANKS; gi++) begin : gBank
      always_comb begin
        preLoad[gi] = 1'b0;
        if (state_r == ST_ISSUE && legal) begin
          if (cmd == CMD_PRE && (ctrl_r[CTRL_ALLBANK_BIT] || bank == gi)) begin
            preLoad[gi] = 1'b1;
          end
          if ((cmd == CMD_READ || cmd == CMD_WRITE) && bank == gi &&
              ctrl_r[CTRL_AUTOPRE_BIT]) begin
            preLoad[gi] = 1'b1;
          end
        end
      end
      dcb_counter #(.WIDTH(9)) preCnt (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .load(preLoad[gi]),
        .loadVal((cmd == CMD_PRE) ? 9'(ROW_PRECHARGE_CYC) :
                 9'(rl) + 9'(bl) + 9'(wr) + 9'(ROW_PRECHARGE_CYC)),
        .busy(preBusy[gi])
      );
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          open_r[gi] <= 1'b0;
        end else if (preLoad[gi]) begin
          open_r[gi] <= 1'b0;
        end else if (state_r == ST_ISSUE && legal && cmd == CMD_ACT &&
                     bank == gi) begin
          open_r[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      memCke <= 1'b0;
      memCs_b <= 1'b1;
      {memRas_b, memCas_b, memWe_b} <= 3'h7;
      memBank <= '0;
      memAddr <= '0;
      selfRef_r <= 1'b0;
    end else begin
      memCs_b <= 1'b1;
      {memRas_b, memCas_b, memWe_b} <= 3'h7;
      if (!selfRef_r) begin
        memCke <= 1'b1;
      end
      if (state_r == ST_ISSUE && legal) begin
        memBank <= 3'(bank);
        memAddr <= addr_r;
        memCs_b <= 1'b0;
        case (cmd)
          CMD_MODE: begin
            memBank <= 3'h0;
            memAddr <= ADDR_WIDTH'(mode_r);
            {memRas_b, memCas_b, memWe_b} <= 3'h0;
          end
          CMD_ACT: {memRas_b, memCas_b, memWe_b} <= 3'h3;
          CMD_READ: begin
            {memRas_b, memCas_b, memWe_b} <= 3'h5;
            memAddr[10] <= ctrl_r[CTRL_AUTOPRE_BIT];
          end
          CMD_WRITE: begin
            {memRas_b, memCas_b, memWe_b} <= 3'h4;
            memAddr[10] <= ctrl_r[CTRL_AUTOPRE_BIT];
          end
          CMD_PRE: begin
            {memRas_b, memCas_b, memWe_b} <= 3'h2;
            memAddr[10] <= ctrl_r[CTRL_ALLBANK_BIT];
          end
          CMD_REF: {memRas_b, memCas_b, memWe_b} <= 3'h1;
          CMD_SREF: begin
            {memRas_b, memCas_b, memWe_b} <= 3'h1;
            memCke <= 1'b0;
            selfRef_r <= 1'b1;
          end
          CMD_SREX: begin
            memCs_b <= 1'b1;
            memCke <= 1'b1;
            selfRef_r <= 1'b0;
          end
          default: memCs_b <= 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Data path, write mask and read capture
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      memDqOut <= '0;
      memDqOe <= 1'b0;
      memByteWriteMask <= 1'b1;
      dqS1_r <= '0;
      dqS2_r <= '0;
      rdata_r <= '0;
    end else begin
      dqS1_r <= memDqIn;
      dqS2_r <= dqS1_r;
      memDqOe <= (state_r == ST_WDATA && lat_r == '0);
      memDqOut <= wdata_r[DATA_WIDTH*beatIdx[1:0] +: DATA_WIDTH];
      memByteWriteMask <= !(state_r == ST_WDATA && lat_r == '0 &&
                            !time_r[beatIdx]);
      if (state_r == ST_RDATA) begin
        rdata_r <= {rdata_r[31-DATA_WIDTH:0], dqS2_r};
      end
    end
  end
endmodule

//--- dcb_host_monitor.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Pin and bus checker
// ------------------------------------------------------------
module dcb_host_chk import dcb_pkg::*; #(
  parameter int ADDR_WIDTH = 14
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pslverr,
  input wire logic memCke,
  input wire logic memCs_b,
  input wire logic memRas_b,
  input wire logic memCas_b,
  input wire logic memWe_b,
  input wire logic [2:0] memBank,
  input wire logic [ADDR_WIDTH-1:0] memAddr
);
  logic [3:0] pins;
  logic exeCmd, modeCmd, actCmd, rdCmd, wrCmd, preCmd, refCmd, bl8R;
  logic [7:0] openMask, sinceWr, sinceRd, dllCnt, halfBl, wrRdGap;
  logic [2:0] clR;
  assign pins = {memCs_b, memRas_b, memCas_b, memWe_b};
  assign exeCmd = !memCs_b && pins != 4'h7;
  assign modeCmd = pins == 4'h0;
  assign actCmd = pins == 4'h3;
  assign rdCmd = pins == 4'h5;
  assign wrCmd = pins == 4'h4;
  assign preCmd = pins == 4'h2;
  assign refCmd = pins == 4'h1;
  assign halfBl = bl8R ? 8'h04 : 8'h02;
  assign wrRdGap = {5'h00, clR} - 8'h01 + halfBl + 8'(WTR_CYC);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      openMask <= 8'h00;
    end else if (actCmd) begin
      openMask <= openMask | (8'h01 << memBank);
    end else if (preCmd && memAddr[10]) begin
      openMask <= 8'h00;
    end else if (preCmd || ((rdCmd || wrCmd) && memAddr[10])) begin
      openMask <= openMask & ~(8'h01 << memBank);
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sinceWr <= 8'hFF;
      sinceRd <= 8'hFF;
    end else begin
      sinceWr <= wrCmd ? 8'h01 : sinceWr + {7'h00, sinceWr != 8'hFF};
      sinceRd <= rdCmd ? 8'h01 : sinceRd + {7'h00, sinceRd != 8'hFF};
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clR <= MODE_RESET_VAL[6:4];
      bl8R <= 1'b0;
      dllCnt <= 8'h00;
    end else if (modeCmd) begin
      clR <= memAddr[6:4];
      bl8R <= memAddr[2:0] == BL8_CODE;
      dllCnt <= memAddr[8] ? 8'hC7 : 8'h00;
    end else if (dllCnt != 8'h00) begin
      dllCnt <= dllCnt - 8'h01;
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  chk_mode_gap:
    assert property (modeCmd |=> !exeCmd) else $error("early command");
  chk_mode_zero:
    assert property (modeCmd |-> memBank == 3'h0 && (memAddr >> 13) == '0)
    else $error("reserved mode bits set");
  chk_ref_idle:
    assert property (refCmd |-> openMask == 8'h00)
    else $error("refresh with open bank");
  chk_col_open:
    assert property ((rdCmd || wrCmd) |-> openMask[memBank])
    else $error("column command to closed bank");
  chk_act_closed:
    assert property (actCmd |-> !openMask[memBank])
    else $error("activate to open bank");
  chk_wr_rd_gap:
    assert property (rdCmd |-> sinceWr >= wrRdGap)
    else $error("write to read too close");
  chk_rd_wr_gap:
    assert property (wrCmd |-> sinceRd >= halfBl + 8'h02)
    else $error("read to write too close");
  chk_col_gap:
    assert property (!((rdCmd && sinceRd < halfBl) ||
      (wrCmd && sinceWr < halfBl))) else $error("bursts overlap");
  chk_dll_read:
    assert property (rdCmd |-> dllCnt == 8'h00)
    else $error("read during lock wait");
  chk_cke_sref:
    assert property ($fell(memCke) |-> refCmd)
    else $error("clock enable dropped without refresh");
  chk_apb_err:
    assert property (psel && penable && paddr > 8'h18 |-> pslverr)
    else $error("unmapped access not flagged");
endmodule
bind dcb_host dcb_host_chk #(.ADDR_WIDTH(ADDR_WIDTH)) i_chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .paddr(paddr), .pslverr(pslverr), .memCke(memCke), .memCs_b(memCs_b),
  .memRas_b(memRas_b), .memCas_b(memCas_b), .memWe_b(memWe_b),
  .memBank(memBank), .memAddr(memAddr)
);

//--- dcb_mem_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Memory device model
// ------------------------------------------------------------
module dcb_mem_model import dcb_pkg::*; (
  input wire logic sys_clk,
  input wire logic memCke,
  input wire logic memCs_b,
  input wire logic memRas_b,
  input wire logic memCas_b,
  input wire logic memWe_b,
  input wire logic [2:0] memBank,
  input wire logic [13:0] memAddr,
  input wire logic [7:0] memDqOut,
  input wire logic memDqOe,
  input wire logic memByteWriteMask,
  output logic [7:0] memDqIn
);
  logic [16:0] modeReg = MODE_RESET_VAL;
  logic [13:0] rowOf [8];
  logic [7:0] cells [int];
  logic [7:0] rdSched [int];
  int wrKeys [$];
  int cyc = 0;
  logic selfRef = 1'b0;
  initial memDqIn = 8'h00;
  // Column of beat i, wrapping in its block
  function automatic int colAt(input int s, input int i);
    int m;
    m = (modeReg[2:0] == BL8_CODE) ? 7 : 3;
    if (modeReg[3]) return (s & ~m) | ((s ^ i) & m);
    return (s & ~m) | ((s + i) & 3) | ((s ^ i) & m & 4);
  endfunction
  always @(posedge sys_clk) begin
    int k;
    int n;
    n = (modeReg[2:0] == BL8_CODE) ? 8 : 4;
    if (memDqOe && wrKeys.size() > 0) begin
      k = wrKeys.pop_front();
      if (!memByteWriteMask) cells[k] = memDqOut;
    end
    if (!memCke && memCs_b == 1'b0 && {memRas_b, memCas_b} == 2'b00) begin
      selfRef <= 1'b1;
    end else if (memCke) begin
      selfRef <= 1'b0;
    end
    // One command per edge, deselect and no-op leave all
    if (memCke && !memCs_b) begin
      case ({memRas_b, memCas_b, memWe_b})
        3'b000: if (memBank == 3'h0) begin
          modeReg <= {4'h0, memAddr[12:9], 1'b0, memAddr[7:0]};
        end
        3'b011: rowOf[memBank] <= memAddr;
        // Zero additive latency, read latency from mode
        3'b101: for (int i = 0; i < n; i++) begin
          k = int'({memBank, rowOf[memBank], 10'(colAt(memAddr[9:0], i))});
          rdSched[cyc + modeReg[6:4] + i] = cells.exists(k) ? cells[k] : ~k[7:0];
        end
        // Auto precharge needs no data action here
        3'b100: for (int i = 0; i < n; i++) begin
          k = int'({memBank, rowOf[memBank], 10'(colAt(memAddr[9:0], i))});
          wrKeys.push_back(k);
        end
        default: ; // Precharge and refresh keep data
      endcase
    end
    memDqIn <= rdSched.exists(cyc) ? rdSched[cyc] : ~memDqIn;
    cyc++;
  end
endmodule

//--- dcb_host_tb.sv
`timescale 1ns/1ps
module dcb_host_tb import dcb_pkg::*;;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, x, w;
  logic pready, pslverr, memCke, memCs_b, memRas_b, memCas_b, memWe_b;
  logic [2:0] memBank;
  logic [13:0] memAddr;
  logic [7:0] memDqOut, memDqIn;
  logic memDqOe, memByteWriteMask;
  int n_fail = 0, total_checks = 0;
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  dcb_host i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .memCke(memCke),
    .memCs_b(memCs_b), .memRas_b(memRas_b), .memCas_b(memCas_b),
    .memWe_b(memWe_b), .memBank(memBank), .memAddr(memAddr),
    .memDqOut(memDqOut), .memDqIn(memDqIn), .memDqOe(memDqOe),
    .memByteWriteMask(memByteWriteMask));
  dcb_mem_model i_mem (.sys_clk(sys_clk), .memCke(memCke),
    .memCs_b(memCs_b), .memRas_b(memRas_b), .memCas_b(memCas_b),
    .memWe_b(memWe_b), .memBank(memBank), .memAddr(memAddr),
    .memDqOut(memDqOut), .memDqOe(memDqOe),
    .memByteWriteMask(memByteWriteMask), .memDqIn(memDqIn));
  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) n_fail++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [3:0] c, input logic [2:0] b,
    input logic [13:0] a, input logic [1:0] f, input logic expErr);
    int n;
    apb(1'b1, ADDR_OFS, {18'h0, a});
    apb(1'b1, CTRL_OFS, {1'b1, 21'h0, f, 1'b0, b, c});
    n = 0;
    do begin
      apb(1'b0, STAT_OFS, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 300);
    check("cmd error", {31'h0, q[2]}, {31'h0, expErr});
    if (q[2] === 1'b1) apb(1'b1, STAT_OFS, 32'h4);
  endtask
  function automatic logic [31:0] expRd(input logic [31:0] x, w,
    input logic [3:0] m, input int s, input bit il);
    logic [31:0] r;
    int c;
    for (int i = 0; i < 4; i++) begin
      c = il ? (s ^ i) : ((s + i) & 3);
      r[8*(3-i) +: 8] = m[c] ? x[8*c +: 8] : w[8*c +: 8];
    end
    return r;
  endfunction
  task automatic end_of_test();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #(20 * 60000);
    n_fail++;
    end_of_test();
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    logic [12:0] mv;
    logic [3:0] m;
    logic [2:0] b;
    int s;
    void'($urandom(71));
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    apb(1'b0, MODE_OFS, 32'h0);
    check("mode reset", q, {15'h0, MODE_RESET_VAL});
    apb(1'b0, TIME_OFS, 32'h0);
    check("time reset", q, TIME_RESET_VAL);
    apb(1'b0, 8'h1C, 32'h0);
    check("unmapped", {q[30:0], err}, 32'h1);
    cmd(CMD_NOP, 3'h0, 14'h0, 2'b00, 1'b0);
    for (int il = 0; il < 2; il++) begin
      mv = il ? 13'h044A : 13'h0542;
      apb(1'b1, MODE_OFS, {19'h7FFFF, mv});
      apb(1'b0, MODE_OFS, 32'h0);
      check("mode field", q, {19'h0, mv});
      cmd(CMD_MODE, 3'h0, 14'h0, 2'b00, 1'b0);
      repeat (DLL_LOCK_CYC) @(posedge sys_clk);
      check("mode pins", {15'h0, i_mem.modeReg}, {19'h0, mv & 13'h1EFF});
      for (int it = 0; it < 3; it++) begin
        b = 3'($urandom_range(7, 0));
        s = $urandom_range(3, 0);
        x = $urandom;
        w = $urandom;
        m = 4'($urandom);
        cmd(CMD_ACT, b, 14'($urandom), 2'b00, 1'b0);
        apb(1'b1, WDATA_OFS, x);
        apb(1'b1, TIME_OFS, 32'h0);
        cmd(CMD_WRITE, b, 14'h0, 2'b00, 1'b0);
        apb(1'b1, WDATA_OFS, w);
        apb(1'b1, TIME_OFS, {28'h0, m});
        cmd(CMD_WRITE, b, 14'h0, 2'b00, 1'b0);
        cmd(CMD_READ, b, 14'(s), 2'b01, 1'b0);
        apb(1'b0, RDATA_OFS, 32'h0);
        check("read data", q, expRd(x, w, m, s, il[0]));
      end
    end
    cmd(CMD_READ, b, 14'h0, 2'b00, 1'b1);
    cmd(CMD_ACT, b, 14'h0015, 2'b00, 1'b0);
    cmd(CMD_REF, 3'h0, 14'h0, 2'b00, 1'b1);
    cmd(CMD_PRE, 3'h0, 14'h0, 2'b10, 1'b0);
    cmd(CMD_PRE, b, 14'h0, 2'b00, 1'b0);
    cmd(CMD_REF, 3'h0, 14'h0, 2'b00, 1'b0);
    cmd(CMD_SREF, 3'h0, 14'h0, 2'b00, 1'b0);
    check("self refresh", {30'h0, q[3], memCke}, 32'h2);
    cmd(CMD_SREX, 3'h0, 14'h0, 2'b00, 1'b0);
    check("self exit", {31'h0, memCke}, 32'h1);
    end_of_test();
  end
endmodule
